// ---- fss_consts.svh ----
// Constants for the scan and seek command logic: opcodes, bit positions, timing
`ifndef FSS_CONSTS_SVH
`define FSS_CONSTS_SVH

`define FSS_CLK_NS          40
`define FSS_STEP_UNIT_NS    1000000
`define FSS_DELAY_UNIT_NS   1000000
`define FSS_PULSE_NS        8000
`define FSS_STEP_UNIT_CYC   (`FSS_STEP_UNIT_NS / `FSS_CLK_NS)
`define FSS_DELAY_UNIT_CYC  (`FSS_DELAY_UNIT_NS / `FSS_CLK_NS)
`define FSS_PULSE_CYC       ((`FSS_PULSE_NS + `FSS_CLK_NS - 1) / `FSS_CLK_NS)

`define FSS_OP_SEEK         8'h0f
`define FSS_OP_SENSE_INT    8'h08
`define FSS_OP_SENSE_DRV    5'h04
`define FSS_OP_SCAN_EQ      5'h11
`define FSS_OP_SCAN_LOW     5'h19
`define FSS_OP_SCAN_HIGH    5'h1d
`define FSS_LEN_SCAN        4'h9
`define FSS_LEN_SEEK        4'h3
`define FSS_LEN_SEEK_EXT    4'h4
`define FSS_LEN_SENSE_DRV   4'h2
`define FSS_LEN_ONE         4'h1
`define FSS_LEN_RES_SCAN    3'h7

`define FSS_SKIP_BIT        5
`define FSS_SAT_BIT         3
`define FSS_NOT_SAT_BIT     2
`define FSS_IC_NORMAL       2'h0
`define FSS_IC_ABNORMAL     2'h1
`define FSS_INVALID_RES     8'h80
`define FSS_WILD_BYTE       8'hff
`define FSS_STEP_RATE_TOP   5'h10

`endif

// ---- fss_drive_model.sv ----
// Drive model: head position per drive, track zero and write protect pins
`timescale 1ns/1ps

module fss_drive_model (
	// Pins from the controller
	input  wire logic       i_step,
	input  wire logic       i_dir,
	// Bench controls
	input  wire logic [1:0] i_sel,
	input  wire logic       i_wp,
	// Pins back to the controller, and head position for the bench
	output logic            o_track0_n,
	output logic            o_wprot_n,
	output int              o_pos
);
	int pos_q [4] = '{0, 0, 0, 0};

	// Head cannot move below track zero
	always @(posedge i_step) begin
		if (i_dir)
			pos_q[i_sel] <= pos_q[i_sel] + 1;
		else if (pos_q[i_sel] > 0)
			pos_q[i_sel] <= pos_q[i_sel] - 1;
	end

	// Only the one selected drive answers
	assign o_pos      = pos_q[i_sel];
	assign o_track0_n = (pos_q[i_sel] != 0);
	assign o_wprot_n  = !i_wp;
endmodule : fss_drive_model

// ---- fss_floppy_cmd.sv ----
// Scan, seek, sense interrupt and sense drive status command execution
`timescale 1ns/1ps
`include "fss_consts.svh"

module fss_floppy_cmd
	import fss_pkg::*;
#(
	parameter int unsigned STEP_UNIT_CYC  = `FSS_STEP_UNIT_CYC,
	parameter int unsigned DELAY_UNIT_CYC = `FSS_DELAY_UNIT_CYC
) (
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_arst_n,
	// Host command bytes
	input  wire logic       i_cmd_wr,
	input  wire logic [7:0] i_cmd_byte,
	output logic            o_cmd_busy,
	// Host result bytes
	output logic            o_res_valid,
	output logic [7:0]      o_res_byte,
	input  wire logic       i_res_rd,
	// Configuration
	input  wire logic       i_extended_track_range,
	input  wire logic       i_wildcard,
	input  wire logic [3:0] i_step_rate,
	input  wire logic [7:0] i_delay_time,
	// Sector data from the read path
	output logic            o_sec_req,
	output logic [7:0]      o_sec_track,
	output logic [7:0]      o_sec_head,
	output logic [7:0]      o_sec_num,
	input  wire logic       i_data_valid,
	input  wire logic [7:0] i_disk_byte,
	input  wire logic [7:0] i_host_byte,
	input  wire logic       i_sec_end,
	input  wire logic       i_sec_deleted,
	input  wire logic       i_read_err,
	input  wire logic [7:0] i_err_status_one,
	input  wire logic [7:0] i_err_status_two,
	// Drive pins, plus transfer count end, drive busy flags and interrupt
	input  wire logic       i_transfer_count_end,
	input  wire logic       i_track0_n,
	input  wire logic       i_wprot_n,
	output logic            o_step,
	output logic            o_dir,
	output logic [3:0]      o_drive_busy,
	output logic            o_irq
);

	fss_main_t   m_q;
	fss_seek_t   seek_q;
	logic [7:0]  cmd_q [0:8];
	logic [3:0]  cnt_q;
	logic [3:0]  len_q;
	logic [3:0]  first_len;
	logic [7:0]  sec_q;
	logic        any_q;
	logic [7:0]  last_two_q;
	logic        diffd_q;
	logic        lt_q;
	logic [7:0]  res_q [0:6];
	logic [2:0]  res_len_q;
	logic [2:0]  res_idx_q;
	logic        res_irq_q;
	logic [2:0]  sync1_q;
	logic [2:0]  sync2_q;
	logic [2:0]  sync3_q;
	logic [2:0]  filt_q;
	logic [11:0] present_track_number_q [0:3];
	logic [11:0] target_q;
	logic [1:0]  seek_drv_q;
	logic        seek_head_q;
	logic [23:0] seek_cnt_q;
	logic [7:0]  seek_status_q;
	logic        pend_q;
	logic        seek_done_q;
	logic        fire_q;
	logic [7:0]  pulse_q;

	logic        transfer_end;
	logic        track0;
	logic        wprot;
	logic [4:0]  op5;
	logic        is_scan;
	logic        is_seek;
	logic        is_sense_int;
	logic        is_sense_drv;
	logic        byte_eq;
	logic        sat;
	logic [7:0]  outcome;
	logic        skipped;
	logic        scan_fin;
	logic        adv;
	logic [1:0]  fin_ic;
	logic [7:0]  fin_one;
	logic [7:0]  fin_two;
	logic        ld;
	logic        ld_irq;
	logic [2:0]  ld_len;
	logic [7:0]  ld_b [0:6];
	logic        sense_take;
	logic        res_last;
	logic [23:0] period;
	logic [11:0] cur_track;

	function automatic logic [3:0] fss_len(input logic [7:0] b, input logic ext);
		if (b[4:0] == `FSS_OP_SCAN_EQ || b[4:0] == `FSS_OP_SCAN_LOW ||
		    b[4:0] == `FSS_OP_SCAN_HIGH)
			return `FSS_LEN_SCAN;
		else if (b == `FSS_OP_SEEK)
			return ext ? `FSS_LEN_SEEK_EXT : `FSS_LEN_SEEK;
		else if (b[4:0] == `FSS_OP_SENSE_DRV)
			return `FSS_LEN_SENSE_DRV;
		else
			return `FSS_LEN_ONE;
	endfunction : fss_len

	// Pin inputs: a change counts once the second and third stages agree
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			sync3_q <= 3'h0;
			filt_q  <= 3'h0;
		end else begin
			sync1_q <= {i_transfer_count_end, ~i_track0_n, ~i_wprot_n};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q  <= (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));
		end
	end

	assign transfer_end = filt_q[2];
	assign track0       = filt_q[1];
	assign wprot        = filt_q[0];

	assign op5          = cmd_q[0][4:0];
	assign is_scan      = fss_len(cmd_q[0], 1'b0) == `FSS_LEN_SCAN;
	assign is_seek      = cmd_q[0] == `FSS_OP_SEEK;
	assign is_sense_int = cmd_q[0] == `FSS_OP_SENSE_INT;
	assign is_sense_drv = op5 == `FSS_OP_SENSE_DRV;
	assign first_len    = fss_len(i_cmd_byte, i_extended_track_range);
	assign sense_take   = (m_q == FSS_M_EXEC) && is_sense_int && pend_q;
	assign res_last     = (res_idx_q + 3'h1) == res_len_q;
	assign cur_track    = present_track_number_q[seek_drv_q];
	assign period       = 24'((`FSS_STEP_RATE_TOP - {1'b0, i_step_rate}) * STEP_UNIT_CYC);

	// Scan decision for the sector now ending
	always_comb begin
		byte_eq = (i_disk_byte == i_host_byte) ||
		          (i_wildcard && (i_disk_byte == `FSS_WILD_BYTE ||
		                          i_host_byte == `FSS_WILD_BYTE));
		sat = !diffd_q || (op5 == `FSS_OP_SCAN_LOW && lt_q) ||
		      (op5 == `FSS_OP_SCAN_HIGH && !lt_q);
		outcome = 8'h00;
		if (!diffd_q)
			outcome[`FSS_SAT_BIT] = 1'b1;
		else if (!sat)
			outcome[`FSS_NOT_SAT_BIT] = 1'b1;
		skipped  = i_sec_deleted && cmd_q[0][`FSS_SKIP_BIT];
		scan_fin = 1'b0;
		fin_ic   = `FSS_IC_NORMAL;
		fin_one  = 8'h00;
		fin_two  = any_q ? last_two_q : 8'h08;
		if (m_q == FSS_M_SCAN) begin
			if (i_read_err) begin
				scan_fin = 1'b1;
				fin_ic   = `FSS_IC_ABNORMAL;
				fin_one  = i_err_status_one;
				fin_two  = i_err_status_two;
			end else if (i_sec_end) begin
				scan_fin = (!skipped && sat) || sec_q == cmd_q[6] || transfer_end;
				if (!skipped)
					fin_two = outcome;
			end else if (transfer_end) begin
				scan_fin = 1'b1;
			end
		end
		adv = (m_q == FSS_M_SCAN) && i_sec_end && !scan_fin;
	end

	// Result bytes to load
	always_comb begin
		ld     = 1'b0;
		ld_irq = 1'b0;
		ld_len = 3'h1;
		for (int i = 0; i < 7; i++)
			ld_b[i] = 8'h00;
		if (m_q == FSS_M_EXEC && !is_scan && !is_seek) begin
			ld = 1'b1;
			if (is_sense_int && pend_q) begin
				ld_irq  = 1'b1;
				ld_b[0] = seek_status_q;
				ld_b[1] = cur_track[7:0];
				ld_b[2] = {cur_track[11:8], 4'h0};
				ld_len  = i_extended_track_range ? 3'h3 : 3'h2;
			end else if (is_sense_drv) begin
				ld_b[0] = {1'b0, wprot, 1'b1, track0, 1'b1, cmd_q[1][2:0]};
			end else begin
				ld_b[0] = `FSS_INVALID_RES;
			end
		end else if (scan_fin) begin
			ld      = 1'b1;
			ld_irq  = 1'b1;
			ld_len  = `FSS_LEN_RES_SCAN;
			ld_b[0] = {fin_ic, 3'h0, cmd_q[1][2:0]};
			ld_b[1] = fin_one;
			ld_b[2] = fin_two;
			ld_b[3] = cmd_q[2];
			ld_b[4] = cmd_q[3];
			ld_b[5] = sec_q;
			ld_b[6] = cmd_q[5];
		end
	end

	// Command collection and main sequencing
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			m_q        <= FSS_M_IDLE;
			cnt_q      <= 4'h0;
			len_q      <= 4'h1;
			sec_q      <= 8'h00;
			any_q      <= 1'b0;
			last_two_q <= 8'h00;
			o_sec_req  <= 1'b0;
			o_cmd_busy <= 1'b0;
			for (int i = 0; i < 9; i++)
				cmd_q[i] <= 8'h00;
		end else begin
			o_sec_req <= 1'b0;
			unique case (m_q)
				FSS_M_IDLE: begin
					if (i_cmd_wr) begin
						cmd_q[cnt_q] <= i_cmd_byte;
						if (cnt_q == 4'h0)
							len_q <= first_len;
						if ((cnt_q == 4'h0 ? first_len : len_q) == cnt_q + 4'h1) begin
							m_q        <= FSS_M_EXEC;
							cnt_q      <= 4'h0;
							o_cmd_busy <= 1'b1;
						end else begin
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end
				FSS_M_EXEC: begin
					if (is_scan) begin
						sec_q     <= cmd_q[4];
						any_q     <= 1'b0;
						o_sec_req <= 1'b1;
						m_q       <= FSS_M_SCAN;
					end else if (is_seek) begin
						// Seek has no result; host must wait for its interrupt
						m_q        <= FSS_M_IDLE;
						o_cmd_busy <= 1'b0;
					end else begin
						m_q <= FSS_M_RES;
					end
				end
				FSS_M_SCAN: begin
					if (i_sec_end && !skipped && !i_read_err) begin
						any_q      <= 1'b1;
						last_two_q <= outcome;
					end
					if (scan_fin) begin
						m_q <= FSS_M_RES;
					end else if (adv) begin
						sec_q     <= sec_q + cmd_q[8];
						o_sec_req <= 1'b1;
					end
				end
				FSS_M_RES: begin
					if (i_res_rd && res_last) begin
						m_q        <= FSS_M_IDLE;
						o_cmd_busy <= 1'b0;
					end
				end
			endcase
		end
	end

	always_comb begin
		o_sec_track = cmd_q[2];
		o_sec_head  = cmd_q[3];
		o_sec_num   = sec_q;
	end

	// Running compare of one sector; first differing byte decides
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			diffd_q <= 1'b0;
			lt_q    <= 1'b0;
		end else if (o_sec_req || m_q == FSS_M_EXEC) begin
			diffd_q <= 1'b0;
			lt_q    <= 1'b0;
		end else if (m_q == FSS_M_SCAN && i_data_valid && !diffd_q && !byte_eq) begin
			diffd_q <= 1'b1;
			lt_q    <= i_disk_byte < i_host_byte;
		end
	end

	// Result phase
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			res_len_q   <= 3'h1;
			res_idx_q   <= 3'h0;
			res_irq_q   <= 1'b0;
			o_res_valid <= 1'b0;
			o_res_byte  <= 8'h00;
			for (int i = 0; i < 7; i++)
				res_q[i] <= 8'h00;
		end else if (ld) begin
			res_q       <= ld_b;
			res_len_q   <= ld_len;
			res_idx_q   <= 3'h0;
			res_irq_q   <= ld_irq;
			o_res_valid <= 1'b1;
			o_res_byte  <= ld_b[0];
		end else if (m_q == FSS_M_RES && i_res_rd) begin
			if (res_last) begin
				o_res_valid <= 1'b0;
				res_idx_q   <= 3'h0;
			end else begin
				res_idx_q  <= res_idx_q + 3'h1;
				o_res_byte <= res_q[res_idx_q + 3'h1];
			end
		end
	end

	// Interrupt: set wins over the clear by the first result read
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			o_irq <= 1'b0;
		else if (seek_done_q || scan_fin)
			o_irq <= 1'b1;
		else if (m_q == FSS_M_RES && i_res_rd && res_idx_q == 3'h0 && res_irq_q)
			o_irq <= 1'b0;
	end

	// Seek engine; runs beside the main sequencer
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			seek_q        <= FSS_S_IDLE;
			target_q      <= 12'h000;
			seek_drv_q    <= 2'h0;
			seek_head_q   <= 1'b0;
			seek_cnt_q    <= 24'h000000;
			seek_status_q <= 8'h00;
			pend_q        <= 1'b0;
			seek_done_q   <= 1'b0;
			fire_q        <= 1'b0;
			o_dir         <= 1'b0;
			o_drive_busy  <= 4'h0;
			for (int i = 0; i < 4; i++)
				present_track_number_q[i] <= 12'h000;
		end else begin
			seek_done_q <= 1'b0;
			fire_q      <= 1'b0;
			if (sense_take)
				pend_q <= 1'b0;
			unique case (seek_q)
				FSS_S_IDLE: begin
					// One drive at a time; a seek sent while another runs is dropped
					if (m_q == FSS_M_EXEC && is_seek) begin
						seek_drv_q   <= cmd_q[1][1:0];
						seek_head_q  <= cmd_q[1][2];
						target_q     <= i_extended_track_range ?
						                {cmd_q[3][7:4], cmd_q[2]} : {4'h0, cmd_q[2]};
						o_drive_busy[cmd_q[1][1:0]] <= 1'b1;
						seek_cnt_q   <= 24'(i_delay_time * DELAY_UNIT_CYC);
						seek_q       <= FSS_S_DELAY;
					end
				end
				FSS_S_DELAY: begin
					if (seek_cnt_q == 24'h000000) begin
						o_dir  <= target_q > cur_track;
						seek_q <= FSS_S_STEP;
					end else begin
						seek_cnt_q <= seek_cnt_q - 24'h000001;
					end
				end
				FSS_S_STEP: begin
					if (seek_cnt_q != 24'h000000) begin
						seek_cnt_q <= seek_cnt_q - 24'h000001;
					end else if (cur_track == target_q || (!o_dir && track0)) begin
						// Track zero while stepping out ends the seek there
						if (!o_dir && track0)
							present_track_number_q[seek_drv_q] <= 12'h000;
						seek_status_q <= {(cur_track == target_q || !o_dir && track0 &&
						                   target_q == 12'h000) ? `FSS_IC_NORMAL :
						                  `FSS_IC_ABNORMAL, 1'b1, 2'h0,
						                  seek_head_q, seek_drv_q};
						o_drive_busy[seek_drv_q] <= 1'b0;
						pend_q      <= 1'b1;
						seek_done_q <= 1'b1;
						seek_q      <= FSS_S_IDLE;
					end else begin
						fire_q     <= 1'b1;
						seek_cnt_q <= period - 24'h000001;
						present_track_number_q[seek_drv_q] <= o_dir ?
							cur_track + 12'h001 : cur_track - 12'h001;
					end
				end
				default: seek_q <= FSS_S_IDLE;
			endcase
		end
	end

	// Step pulse shaper
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pulse_q <= 8'h00;
			o_step  <= 1'b0;
		end else begin
			o_step  <= fire_q || pulse_q > 8'h01;
			pulse_q <= fire_q ? 8'(`FSS_PULSE_CYC) :
			           (pulse_q != 8'h00 ? pulse_q - 8'h01 : 8'h00);
		end
	end

endmodule : fss_floppy_cmd

// ---- fss_floppy_cmd_chk.sv ----
// Port assertions for the scan and seek command logic
`timescale 1ns/1ps
`include "fss_consts.svh"

module fss_floppy_cmd_chk #(
	parameter int unsigned STEP_UNIT_CYC = `FSS_STEP_UNIT_CYC
) (
	// Clock and reset
	input wire logic       i_core_clk,
	input wire logic       i_arst_n,
	// Watched ports
	input wire logic       i_res_rd,
	input wire logic [3:0] i_step_rate,
	input wire logic       o_cmd_busy,
	input wire logic       o_res_valid,
	input wire logic [7:0] o_res_byte,
	input wire logic       o_sec_req,
	input wire logic       o_step,
	input wire logic       o_dir,
	input wire logic [3:0] o_drive_busy,
	input wire logic       o_irq
);
	logic [31:0] hi_q;
	logic [31:0] gap_q;
	logic [31:0] period;
	logic        stepped_q;

	assign period = (32'd16 - {28'h0, i_step_rate}) * STEP_UNIT_CYC;

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			hi_q <= 32'h0;
		else
			hi_q <= o_step ? hi_q + 32'h1 : 32'h0;
	end

	// First step of a seek has no predecessor, so it is not timed
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			gap_q     <= 32'h0;
			stepped_q <= 1'b0;
		end else begin
			gap_q     <= $rose(o_step) ? 32'h1 : gap_q + 32'h1;
			stepped_q <= $rose(o_step) | (stepped_q & ~$rose(o_irq));
		end
	end

	default clocking cb_main @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);

	sequence s_step_rise;
		$rose(o_step);
	endsequence
	sequence s_irq_read;
		o_irq && o_res_valid && i_res_rd;
	endsequence
	sequence s_res_wait;
		o_res_valid && !i_res_rd;
	endsequence

	a_step_width: assert property ($fell(o_step) |-> hi_q == `FSS_PULSE_CYC)
		else $error("Step pulse width wrong");
	a_step_gap: assert property (s_step_rise ##0 stepped_q |-> gap_q == period)
		else $error("Step period wrong");
	a_irq_period: assert property ($rose(o_irq) && stepped_q |-> gap_q == period)
		else $error("Seek interrupt not one period after last step");
	a_irq_clear: assert property (s_irq_read |=> !o_irq)
		else $error("Interrupt not cleared by first result read");
	a_res_hold: assert property (s_res_wait |=> o_res_valid && $stable(o_res_byte))
		else $error("Result byte changed before read");
	a_res_busy: assert property (o_res_valid |-> o_cmd_busy)
		else $error("Result shown while not busy");
	a_req_pulse: assert property (o_sec_req |-> (o_cmd_busy && !o_res_valid) ##1 !o_sec_req)
		else $error("Sector request outside scan or too long");
	a_dir_hold: assert property (o_step |-> $stable(o_dir))
		else $error("Direction moved during step");
	a_busy_one: assert property (o_drive_busy != 4'h0 |-> $onehot(o_drive_busy))
		else $error("More than one drive busy");
	a_step_busy: assert property (s_step_rise |-> (o_drive_busy != 4'h0) [*8])
		else $error("Step without busy drive");
endmodule : fss_floppy_cmd_chk

bind fss_floppy_cmd fss_floppy_cmd_chk #(.STEP_UNIT_CYC(STEP_UNIT_CYC)) i_chk (
	.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_res_rd(i_res_rd),
	.i_step_rate(i_step_rate), .o_cmd_busy(o_cmd_busy), .o_res_valid(o_res_valid),
	.o_res_byte(o_res_byte), .o_sec_req(o_sec_req), .o_step(o_step), .o_dir(o_dir),
	.o_drive_busy(o_drive_busy), .o_irq(o_irq)
);

// ---- fss_pkg.sv ----
// Types for the scan and seek command logic
package fss_pkg;

	typedef enum logic [3:0] {
		FSS_M_IDLE = 4'b0001,
		FSS_M_EXEC = 4'b0010,
		FSS_M_SCAN = 4'b0100,
		FSS_M_RES  = 4'b1000
	} fss_main_t;

	typedef enum logic [2:0] {
		FSS_S_IDLE  = 3'b001,
		FSS_S_DELAY = 3'b010,
		FSS_S_STEP  = 3'b100
	} fss_seek_t;

endpackage : fss_pkg

// ---- tb_top.sv ----
// Self-checking bench for the scan and seek command logic
`timescale 1ns/1ps
`include "fss_consts.svh"

module tb_top;
	localparam int unsigned SU = 40;
	localparam int unsigned DU = 4;
	localparam logic [4:0] OPS [3] = '{`FSS_OP_SCAN_EQ, `FSS_OP_SCAN_LOW, `FSS_OP_SCAN_HIGH};
	logic       i_core_clk, i_arst_n, i_cmd_wr, i_res_rd, i_extended_track_range, i_wildcard;
	logic       i_data_valid, i_sec_end, i_sec_deleted, i_read_err, i_transfer_count_end;
	logic       o_cmd_busy, o_res_valid, o_sec_req, o_step, o_dir, o_irq, track0_n, wprot_n, wp;
	logic [1:0] sel;
	logic [3:0] i_step_rate, o_drive_busy;
	logic [7:0] i_cmd_byte, i_delay_time, i_disk_byte, i_host_byte, i_err_status_one;
	logic [7:0] i_err_status_two, o_res_byte, o_sec_track, o_sec_head, o_sec_num;
	logic [7:0] cb [9];
	logic [7:0] res [7];
	int         error_cnt, compares, seed, pos;

	fss_floppy_cmd #(.STEP_UNIT_CYC(SU), .DELAY_UNIT_CYC(DU)) i_dut (
		.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_cmd_wr(i_cmd_wr),
		.i_cmd_byte(i_cmd_byte), .o_cmd_busy(o_cmd_busy), .o_res_valid(o_res_valid),
		.o_res_byte(o_res_byte), .i_res_rd(i_res_rd),
		.i_extended_track_range(i_extended_track_range), .i_wildcard(i_wildcard),
		.i_step_rate(i_step_rate), .i_delay_time(i_delay_time), .o_sec_req(o_sec_req),
		.o_sec_track(o_sec_track), .o_sec_head(o_sec_head), .o_sec_num(o_sec_num),
		.i_data_valid(i_data_valid), .i_disk_byte(i_disk_byte), .i_host_byte(i_host_byte),
		.i_sec_end(i_sec_end), .i_sec_deleted(i_sec_deleted), .i_read_err(i_read_err),
		.i_err_status_one(i_err_status_one), .i_err_status_two(i_err_status_two),
		.i_transfer_count_end(i_transfer_count_end), .i_track0_n(track0_n),
		.i_wprot_n(wprot_n), .o_step(o_step), .o_dir(o_dir), .o_drive_busy(o_drive_busy),
		.o_irq(o_irq)
	);

	fss_drive_model i_drv (
		.i_step(o_step), .i_dir(o_dir), .i_sel(sel), .i_wp(wp),
		.o_track0_n(track0_n), .o_wprot_n(wprot_n), .o_pos(pos)
	);

	function automatic int rnd(input int m);
		return int'($unsigned($random(seed)) % m);
	endfunction : rnd

	task automatic tick;
		@(posedge i_core_clk);
		#2;
	endtask : tick

	task automatic chk(input logic [15:0] exp, input logic [15:0] act);
		compares++;
		if (act !== exp) begin
			error_cnt++;
			$display("Error at %0t: expected %h, got %h", $time, exp, act);
		end
	endtask : chk

	task automatic send(input int n);
		int k;
		k = 0;
		while (o_cmd_busy !== 1'b0 && k < 1000) begin
			tick;
			k++;
		end
		chk(16'h0, {15'h0, o_cmd_busy});
		for (int i = 0; i < n; i++) begin
			i_cmd_wr   = 1'b1;
			i_cmd_byte = cb[i];
			tick;
		end
		i_cmd_wr = 1'b0;
	endtask : send

	// Extra cycle before each read; a scan interrupt rises on the same edge as o_res_valid
	task automatic get(input int n);
		int k;
		for (int i = 0; i < n; i++) begin
			k = 0;
			while (o_res_valid !== 1'b1 && k < 1000) begin
				tick;
				k++;
			end
			tick;
			chk(16'h1, {15'h0, o_res_valid});
			res[i]   = o_res_byte;
			i_res_rd = 1'b1;
			tick;
			i_res_rd = 1'b0;
			tick;
		end
	endtask : get

	task automatic seek(input logic [1:0] drv, input logic hd, input logic [11:0] tgt,
		input logic ext);
		int k, first, dmin;
		i_extended_track_range = ext;
		i_step_rate  = 4'(rnd(11));
		i_delay_time = 8'(rnd(4));
		dmin  = int'(i_delay_time) * int'(DU);
		sel   = drv;
		cb[0] = `FSS_OP_SEEK;
		cb[1] = {5'h00, hd, drv};
		cb[2] = tgt[7:0];
		cb[3] = {tgt[11:8], 4'h0};
		send(ext ? 4 : 3);
		tick;
		tick;
		chk(16'(4'h1 << drv), 16'(o_drive_busy));
		k = 0;
		first = -1;
		while (o_irq !== 1'b1 && k < 20000) begin
			if (first < 0 && o_step === 1'b1)
				first = k;
			tick;
			k++;
		end
		chk(16'h1, {15'h0, o_irq});
		chk(16'(tgt), 16'(pos));
		chk(16'h1, {15'h0, first >= dmin});
		cb[0] = `FSS_OP_SENSE_INT;
		send(1);
		get(ext ? 3 : 2);
		chk({8'h00, 2'b00, 1'b1, 2'b00, hd, drv}, 16'(res[0]));
		chk(16'(tgt[7:0]), 16'(res[1]));
		if (ext)
			chk(16'({tgt[11:8], 4'h0}), 16'(res[2]));
		chk(16'h0, {15'h0, o_irq});
		chk(16'h0, 16'(o_drive_busy));
	endtask : seek

	task automatic scan(input int kind, input int mode);
		logic [7:0] sec, last_sector_of_track, st2, step, d, h;
		logic       sk, del, done;
		int         k, idx, rel;
		sk    = 1'(rnd(2));
		step  = 8'(1 + rnd(3));
		sec   = 8'(rnd(200));
		last_sector_of_track   = sec + step * 8'(rnd(4));
		i_wildcard       = 1'(rnd(2));
		i_err_status_one = 8'(rnd(256));
		i_err_status_two = 8'(rnd(256));
		cb = '{{2'b01, sk, OPS[kind]}, 8'h05, 8'(rnd(80)), 8'(rnd(2)), sec, 8'(rnd(4)),
			last_sector_of_track, 8'h1b, step};
		send(9);
		st2  = 8'h08;
		done = 1'b0;
		idx  = 0;
		while (!done) begin
			k = 0;
			while (o_sec_req !== 1'b1 && k < 1000) begin
				tick;
				k++;
			end
			chk(16'h1, {15'h0, o_sec_req});
			chk(16'(sec), 16'(o_sec_num));
			chk({cb[2], cb[3]}, {o_sec_track, o_sec_head});
			// Compare restarts while the request stands, so data follows it
			tick;
			if (mode == 1 && idx == 1) begin
				i_transfer_count_end = 1'b1;
				done = 1'b1;
			end else begin
				rel = 0;
				for (int b = 0; b < 4; b++) begin
					d = (rnd(8) == 0) ? 8'hff : 8'(rnd(256));
					h = (rnd(2) == 0) ? d : 8'(rnd(256));
					i_data_valid = 1'b1;
					i_disk_byte  = d;
					i_host_byte  = h;
					tick;
					if (rel == 0 && d != h && !(i_wildcard && (d == 8'hff || h == 8'hff)))
						rel = (d < h) ? -1 : 1;
				end
				i_data_valid = 1'b0;
				del = 1'(rnd(2));
				if (mode == 2) begin
					i_read_err = 1'b1;
					tick;
					i_read_err = 1'b0;
					done = 1'b1;
				end else begin
					i_sec_end     = 1'b1;
					i_sec_deleted = del;
					tick;
					i_sec_end = 1'b0;
					if (!(del && sk)) begin
						st2 = (rel == 0) ? 8'h08 : ((kind == 1 && rel < 0) ||
							(kind == 2 && rel > 0)) ? 8'h00 : 8'h04;
						done = !st2[2];
					end
					if (sec == last_sector_of_track)
						done = 1'b1;
					if (!done)
						sec = sec + step;
				end
			end
			idx++;
		end
		get(7);
		i_transfer_count_end = 1'b0;
		chk((mode == 2) ? 16'h0045 : 16'h0005, 16'(res[0]));
		if (mode == 2) begin
			chk(16'(i_err_status_one), 16'(res[1]));
			chk(16'(i_err_status_two), 16'(res[2]));
		end else
			chk(16'(st2), 16'(res[2]));
		for (int i = 3; i < 7; i++)
			chk(16'((i == 5) ? sec : cb[i - 1]), 16'(res[i]));
	endtask : scan

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end

	// Longest run is a few seeks of up to six steps at the slowest rate
	initial begin
		repeat (40000) @(posedge i_core_clk);
		error_cnt++;
		stop_test;
	end

	initial begin
		seed = 32'h8eb86552;
		{i_cmd_wr, i_res_rd, i_extended_track_range, i_wildcard, i_data_valid} = '0;
		{i_sec_end, i_sec_deleted, i_read_err, i_transfer_count_end, wp, sel} = '0;
		{i_step_rate, i_cmd_byte, i_delay_time, i_disk_byte, i_host_byte} = '0;
		{i_err_status_one, i_err_status_two} = '0;
		i_arst_n = 1'b0;
		repeat (8) @(posedge i_core_clk);
		#2 i_arst_n = 1'b1;
		repeat (4) tick;
		cb[0] = `FSS_OP_SENSE_INT;
		send(1);
		get(1);
		chk(16'(`FSS_INVALID_RES), 16'(res[0]));
		seek(2'h1, 1'b1, 12'(3 + rnd(4)), 1'b0);
		seek(2'h1, 1'b0, 12'h001, 1'b1);
		seek(2'h1, 1'b1, 12'h000, 1'b0);
		sel = 2'h2;
		for (int w = 0; w < 2; w++) begin
			wp = w[0];
			repeat (5) tick;
			cb[0] = {3'b000, `FSS_OP_SENSE_DRV};
			cb[1] = 8'h06;
			send(2);
			get(1);
			chk({8'h00, 1'b0, wp, 4'hf, 2'h2}, 16'(res[0]));
			chk(16'h0, {15'h0, o_irq});
		end
		for (int i = 0; i < 9; i++)
			scan(i % 3, (i < 7) ? 0 : i - 6);
		stop_test;
	end
endmodule : tb_top
